// [hw/sfd_defs.vh]
// constants for the sensor fault diagnostics block
`ifndef SFD_DEFS_VH
`define SFD_DEFS_VH
`define SFD_CLK_MHZ 200
`define SFD_TICK_US 1
`define SFD_TICK_CYCLES (`SFD_CLK_MHZ * `SFD_TICK_US)
`define SFD_UV_HOLD_MS 8
`define SFD_UV_HOLD_TICKS (`SFD_UV_HOLD_MS * 1000 / `SFD_TICK_US)
`define SFD_PO_DELAY_US 1000
`define SFD_PO_DELAY_TICKS (`SFD_PO_DELAY_US / `SFD_TICK_US)
`define SFD_ADDR_CFG 4'h0
`define SFD_ADDR_STATUS 4'h4
`define SFD_ADDR_MEMADDR 4'h8
`define SFD_ADDR_MEMDATA 4'hC
`define SFD_CFG_OV_EN 0
`define SFD_CFG_UV_EN 1
`define SFD_CFG_OOR_EN 2
`define SFD_CFG_SPM_EN 3
`define SFD_CFG_TEMP_EN 4
`define SFD_CFG_DIAG_HIZ 5
`define SFD_CFG_POR_HOLD 6
`define SFD_CFG_SPM_ANA 7
`define SFD_CFG_SPM_DIG 8
`define SFD_CFG_RATIO_LSB 12
`define SFD_CFG_LOCK_LSB 20
`define SFD_CFG_RESET 32'h0000715F
`define SFD_CFG_MASK 32'h00FFF1FF
`define SFD_FLAG_ECC 0
`define SFD_FLAG_SP 2
`define SFD_FLAG_UV 3
`define SFD_FLAG_OV 4
`define SFD_FLAG_TEMP 5
`define SFD_FLAG_OOR_LO 6
`define SFD_FLAG_OOR_HI 7
`define SFD_OUT_NORMAL 2'h0
`define SFD_OUT_DIAG 2'h1
`define SFD_OUT_HIZ 2'h2
`define SFD_OUT_WAIT 2'h3
`define SFD_LOCK_CODE 4'hC
`define SFD_TEMP_HI 12'sh0A0
`define SFD_TEMP_LO (-12'sh037)
`define SFD_MEM_DATA_W 26
`define SFD_RESP_SBE_BIT 28
`define SFD_RESP_DBE_BIT 29
`endif

// [hw/sfd_sync.v]
// two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module sfd_sync #(
  parameter W = 1
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [W-1:0] async_i,
  output reg [W-1:0] sync_o
);
  // first stage is read by the second stage only
  reg [W-1:0] meta;

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule // sfd_sync
`default_nettype wire

// [hw/sfd_diag.v]
// fault supervision, output fault state and memory read formatting
`timescale 1ns/1ps
`default_nettype none
`include "sfd_defs.vh"
// Behaviour
// - separate enables for overvoltage, undervoltage, out of range, path monitor, temperature.
// - errors drive coded diagnostic output by default, or high impedance if configured.
// - path monitor injects reference; flags error when result leaves tolerance window.
// - reference shares converter slots; ratio set by monitor_sample_ratio.
// - analog and digital path checks have own enables; digital on, analog off.
// - out of range flags on path clamping or converter input overrange.
// - undervoltage holds fault state; normal output returns when supply recovers.
// - high impedance in reset; then follow undervoltage, no data before power_on_delay.
// - hold select 0 clears immediately; 1 holds undervoltage error about 8 ms.
// - overvoltage sets above upper level, clears below lower level, else holds.
// - overvoltage needs lock; unlocked overvoltage enters programming mode, high impedance.
// - above highvolt_level the output is high impedance regardless of configuration.
// - temperature error above 160 C or below -55 C drives diagnostic response.
// - single-bit memory errors are corrected transparently.
// - double-bit memory error raises internal fault and forces high impedance.
// - read response has data in bits 0..25, zeros in 26..31 when clean.
// - corrected single-bit error sets response bit 28.
// - double-bit error sets response bit 29.
// - overvoltage enters programming mode whenever lock code is not 12.
module sfd_diag #(
  parameter [23:0] UV_HOLD_TICKS = `SFD_UV_HOLD_TICKS,
  parameter [23:0] PO_DELAY_TICKS = `SFD_PO_DELAY_TICKS,
  parameter REF_W = 16,
  parameter [15:0] REF_LO = 16'h7000,
  parameter [15:0] REF_HI = 16'h9000
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  input wire low_supply_detector_i,
  input wire overvolt_upper_level_i,
  input wire overvolt_lower_level_i,
  input wire highvolt_level_i,
  input wire signed [11:0] temp_c_i,
  input wire clamp_low_i,
  input wire clamp_high_i,
  input wire adc_overrange_i,
  input wire adc_slot_i,
  input wire adc_valid_i,
  input wire [REF_W-1:0] adc_data_i,
  input wire dsp_check_fail_i,
  output wire [7:0] mem_addr_o,
  output reg mem_rd_o,
  input wire [31:0] mem_word_i,
  input wire mem_ack_i,
  output wire adc_ref_sel_o,
  output reg [1:0] out_state_o,
  output reg [7:0] diag_flags_o,
  output reg prog_mode_o,
  output reg ecc_fault_o
);
  reg [31:0] cfg;
  reg [7:0] mem_addr;
  reg done;
  reg mem_busy;
  reg [7:0] tick_cnt;
  reg tick;
  reg [23:0] po_cnt;
  reg po_done;
  reg [23:0] uv_cnt;
  reg uv_state;
  reg ov_state;
  reg [7:0] slot_cnt;
  reg ref_busy;
  reg sp_ana_bad;
  reg [31:0] next_rdata;
  reg [27:0] ecc_res;
  reg [7:0] next_flags;
  reg [1:0] next_out;
  wire [3:0] pins_s;
  wire uv_s;
  wire ovu_s;
  wire ovl_s;
  wire hv_s;
  wire locked;
  wire [7:0] ratio;
  wire req;

  sfd_sync #(
    .W(4)
  ) u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({highvolt_level_i, overvolt_lower_level_i, overvolt_upper_level_i,
      low_supply_detector_i}),
    .sync_o(pins_s)
  );

  assign uv_s = pins_s[0];
  assign ovu_s = pins_s[1];
  assign ovl_s = pins_s[2];
  assign hv_s = pins_s[3];
  assign ratio = cfg[`SFD_CFG_RATIO_LSB+7:`SFD_CFG_RATIO_LSB];
  assign locked = (cfg[`SFD_CFG_LOCK_LSB+3:`SFD_CFG_LOCK_LSB] == `SFD_LOCK_CODE);
  assign mem_addr_o = mem_addr;
  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~done;

  // secded decode: cw[0] overall parity, cw[31:1] hamming positions 1..31
  function [27:0] ecc_decode;
    input [31:0] cw;
    reg [31:0] fix;
    reg [4:0] syn;
    reg [25:0] data;
    reg par;
    reg sbe;
    reg dbe;
    integer i;
    integer k;
    begin
      syn = 5'h00;
      par = ^cw;
      for (i = 1; i < 32; i = i + 1) begin
        if (cw[i]) begin
          syn = syn ^ i[4:0];
        end
      end
      sbe = par;
      dbe = ~par & (syn != 5'h00);
      fix = cw;
      if (par && (syn != 5'h00)) begin
        fix[syn] = ~cw[syn];
      end
      data = 26'h0000000;
      k = 0;
      for (i = 3; i < 32; i = i + 1) begin
        if ((i != 4) && (i != 8) && (i != 16)) begin
          data[k] = fix[i];
          k = k + 1;
        end
      end
      ecc_decode = {dbe, sbe, data};
    end
  endfunction

  // 1 us enable pulse; every slow timer counts on it
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      tick_cnt <= 8'h00;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == `SFD_TICK_CYCLES - 1);
      if (tick_cnt == `SFD_TICK_CYCLES - 1) begin
        tick_cnt <= 8'h00;
      end else begin
        tick_cnt <= tick_cnt + 8'h01;
      end
    end
  end

  // power-on delay after reset release
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      po_cnt <= 24'h000000;
      po_done <= 1'b0;
    end else if (tick && !po_done) begin
      po_cnt <= po_cnt + 24'h000001;
      po_done <= (po_cnt >= PO_DELAY_TICKS - 24'h000001);
    end
  end

  // undervoltage state with optional recovery hold
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      uv_state <= 1'b0;
      uv_cnt <= 24'h000000;
    end else if (uv_s) begin
      uv_state <= 1'b1;
      uv_cnt <= 24'h000000;
    end else if (uv_state) begin
      if (!cfg[`SFD_CFG_POR_HOLD]) begin
        uv_state <= 1'b0;
      end else if (tick) begin
        // hold lets the signal path settle before data is trusted
        if (uv_cnt >= UV_HOLD_TICKS - 24'h000001) begin
          uv_state <= 1'b0;
        end else begin
          uv_cnt <= uv_cnt + 24'h000001;
        end
      end
    end
  end

  // overvoltage hysteresis between the two comparator levels
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      ov_state <= 1'b0;
    end else if (ovu_s) begin
      ov_state <= 1'b1;
    end else if (!ovl_s) begin
      ov_state <= 1'b0;
    end
  end

  // reference slot scheduling and analog window check
  assign adc_ref_sel_o = cfg[`SFD_CFG_SPM_EN] & cfg[`SFD_CFG_SPM_ANA] &
    (slot_cnt == ratio);

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      slot_cnt <= 8'h00;
      ref_busy <= 1'b0;
      sp_ana_bad <= 1'b0;
    end else begin
      if (adc_slot_i) begin
        ref_busy <= adc_ref_sel_o;
        if (slot_cnt >= ratio) begin
          slot_cnt <= 8'h00;
        end else begin
          slot_cnt <= slot_cnt + 8'h01;
        end
      end else if (adc_valid_i) begin
        ref_busy <= 1'b0;
      end
      if (adc_valid_i && ref_busy && !adc_slot_i) begin
        sp_ana_bad <= (adc_data_i < REF_LO) || (adc_data_i > REF_HI);
      end
      if (!cfg[`SFD_CFG_SPM_ANA]) begin
        sp_ana_bad <= 1'b0;
      end
    end
  end

  // detector flags, each masked by its enable except the memory fault flag
  always @* begin
    next_flags = 8'h00;
    next_flags[`SFD_FLAG_ECC] = ecc_fault_o;
    next_flags[`SFD_FLAG_UV] = cfg[`SFD_CFG_UV_EN] & uv_state;
    next_flags[`SFD_FLAG_OV] = cfg[`SFD_CFG_OV_EN] & ov_state & locked;
    next_flags[`SFD_FLAG_SP] = cfg[`SFD_CFG_SPM_EN] &
      ((cfg[`SFD_CFG_SPM_ANA] & sp_ana_bad) |
      (cfg[`SFD_CFG_SPM_DIG] & dsp_check_fail_i));
    next_flags[`SFD_FLAG_TEMP] = cfg[`SFD_CFG_TEMP_EN] &
      ((temp_c_i > `SFD_TEMP_HI) || (temp_c_i < `SFD_TEMP_LO));
    next_flags[`SFD_FLAG_OOR_LO] = cfg[`SFD_CFG_OOR_EN] &
      (clamp_low_i | (adc_overrange_i & adc_data_i[REF_W-1]));
    next_flags[`SFD_FLAG_OOR_HI] = cfg[`SFD_CFG_OOR_EN] &
      (clamp_high_i | (adc_overrange_i & ~adc_data_i[REF_W-1]));
  end

  // output state priority: forced high impedance, then errors, then start-up wait
  always @* begin
    if (hv_s || (ov_state && !locked) || ecc_fault_o) begin
      next_out = `SFD_OUT_HIZ;
    end else if (next_flags != 8'h00) begin
      if (cfg[`SFD_CFG_DIAG_HIZ]) begin
        next_out = `SFD_OUT_HIZ;
      end else begin
        next_out = `SFD_OUT_DIAG;
      end
    end else if (!po_done) begin
      next_out = `SFD_OUT_WAIT;
    end else begin
      next_out = `SFD_OUT_NORMAL;
    end
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      out_state_o <= `SFD_OUT_HIZ;
      diag_flags_o <= 8'h00;
      prog_mode_o <= 1'b0;
    end else begin
      out_state_o <= next_out;
      diag_flags_o <= next_flags;
      prog_mode_o <= ov_state & ~locked;
    end
  end

  // register read mux
  always @* begin
    case (avs_address_i)
      `SFD_ADDR_CFG: next_rdata = cfg;
      `SFD_ADDR_STATUS: next_rdata = {19'h00000, po_done, hv_s, prog_mode_o,
        out_state_o, diag_flags_o};
      `SFD_ADDR_MEMADDR: next_rdata = {24'h000000, mem_addr};
      default: next_rdata = 32'h00000000;
    endcase
  end

  always @* begin
    ecc_res = ecc_decode(mem_word_i);
  end

  // avalon slave: one wait cycle per access, memory reads wait for the array
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      cfg <= `SFD_CFG_RESET;
      mem_addr <= 8'h00;
      done <= 1'b0;
      mem_busy <= 1'b0;
      mem_rd_o <= 1'b0;
      avs_readdata_o <= 32'h00000000;
      ecc_fault_o <= 1'b0;
    end else begin
      done <= 1'b0;
      mem_rd_o <= 1'b0;
      if (req && !done) begin
        if (avs_read_i && (avs_address_i == `SFD_ADDR_MEMDATA)) begin
          if (!mem_busy) begin
            mem_busy <= 1'b1;
            mem_rd_o <= 1'b1;
          end else if (mem_ack_i) begin
            mem_busy <= 1'b0;
            done <= 1'b1;
            avs_readdata_o <= {2'b00, ecc_res[27], ecc_res[26], 2'b00,
              ecc_res[25:0]};
            if (ecc_res[27]) begin
              ecc_fault_o <= 1'b1;
            end
          end
        end else begin
          done <= 1'b1;
          avs_readdata_o <= next_rdata;
          if (avs_write_i && (avs_address_i == `SFD_ADDR_CFG)) begin
            if (avs_byteenable_i[0]) begin
              cfg[7:0] <= avs_writedata_i[7:0];
            end
            if (avs_byteenable_i[1]) begin
              cfg[15:8] <= avs_writedata_i[15:8] & 8'hF1;
            end
            if (avs_byteenable_i[2]) begin
              cfg[23:16] <= avs_writedata_i[23:16];
            end
          end
          if (avs_write_i && (avs_address_i == `SFD_ADDR_MEMADDR) &&
              avs_byteenable_i[0]) begin
            mem_addr <= avs_writedata_i[7:0];
          end
        end
      end
    end
  end
endmodule // sfd_diag
`default_nettype wire

// [tb/sfd_diag_asserts.sv]
// assertions on the ports of the fault supervision block
`timescale 1ns/1ps
`default_nettype none
module sfd_diag_asserts (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic highvolt_level_i,
  input wire logic signed [11:0] temp_c_i,
  input wire logic clamp_low_i,
  input wire logic clamp_high_i,
  input wire logic adc_overrange_i,
  input wire logic mem_rd_o,
  input wire logic [1:0] out_state_o,
  input wire logic [7:0] diag_flags_o,
  input wire logic prog_mode_o,
  input wire logic ecc_fault_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire mem_done = avs_read_i && !avs_waitrequest_o && avs_address_i == 4'hC;
  // five cycles cover the two synchroniser stages and the output register
  AST_HV_HIZ: assert property (highvolt_level_i [*5] |-> out_state_o == 2'h2)
    else $error("high voltage without high impedance");
  AST_ECC_HIZ: assert property (ecc_fault_o && $past(ecc_fault_o) |-> out_state_o == 2'h2)
    else $error("memory fault without high impedance");
  AST_PROG_HIZ: assert property (prog_mode_o && $past(prog_mode_o) |-> out_state_o == 2'h2)
    else $error("programming mode without high impedance");
  AST_TEMP_CAUSE: assert property ($rose(diag_flags_o[5]) |->
    $past(temp_c_i) > 160 || $past(temp_c_i) < -55) else $error("temperature flag without cause");
  AST_OOR_CAUSE: assert property ($rose(|diag_flags_o[7:6]) |-> $past(clamp_low_i) ||
    $past(clamp_high_i) || $past(adc_overrange_i)) else $error("range flag without cause");
  AST_RESP_ZERO: assert property (mem_done |-> avs_readdata_o[31:30] == 2'h0 &&
    avs_readdata_o[27:26] == 2'h0) else $error("read response top bits not zero");
  AST_DBE_FAULT: assert property (mem_done && avs_readdata_o[29] |-> ##[0:2] ecc_fault_o)
    else $error("double error without fault");
  AST_NORMAL_CLEAN: assert property (out_state_o == 2'h0 |-> diag_flags_o == 8'h00 &&
    !prog_mode_o) else $error("normal output with error present");
  AST_MEM_PULSE: assert property ($rose(avs_read_i) && avs_address_i == 4'hC |=>
    mem_rd_o ##1 !mem_rd_o) else $error("memory read strobe wrong");
  AST_WAIT_ONE: assert property ((avs_read_i || avs_write_i) && !avs_waitrequest_o |=>
    avs_waitrequest_o || !(avs_read_i || avs_write_i)) else $error("waitrequest low too long");
  cover property (mem_done && avs_readdata_o[28]);
  cover property (prog_mode_o);
  cover property (out_state_o == 2'h1 ##1 out_state_o == 2'h0);
endmodule // sfd_diag_asserts
bind sfd_diag sfd_diag_asserts u_sfd_chk (.clk_i, .sys_rst_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .highvolt_level_i, .temp_c_i, .clamp_low_i,
  .clamp_high_i, .adc_overrange_i, .mem_rd_o, .out_state_o, .diag_flags_o, .prog_mode_o,
  .ecc_fault_o);
`default_nettype wire

// [tb/sfd_mem_model.sv]
// memory partner answering coded word reads after a set latency
`timescale 1ns/1ps
`default_nettype none
module sfd_mem_model (
  input wire logic clk_i,
  input wire logic rd_i,
  input wire logic [31:0] word_i,
  input wire logic [3:0] lat_i,
  output logic ack_o = 1'b0,
  output logic [31:0] word_o = 32'h0
);
  logic busy = 1'b0;
  logic [3:0] cnt = 4'h0;
  // the word is only valid with ack, so it toggles otherwise to expose early sampling
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    word_o <= ~word_o;
    if (rd_i) begin
      busy <= 1'b1;
      cnt <= lat_i;
    end else if (busy && cnt == 4'h0) begin
      busy <= 1'b0;
      ack_o <= 1'b1;
      word_o <= word_i;
    end else if (busy) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule // sfd_mem_model
`default_nettype wire

// [tb/tb_top.sv]
// testbench for the sensor fault diagnostics block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic low_supply_detector_i = 1'b0;
  logic overvolt_upper_level_i = 1'b0;
  logic overvolt_lower_level_i = 1'b0;
  logic highvolt_level_i = 1'b0;
  logic signed [11:0] temp_c_i = 12'sd25;
  logic clamp_low_i = 1'b0;
  logic clamp_high_i = 1'b0;
  logic adc_overrange_i = 1'b0;
  logic adc_slot_i = 1'b0;
  logic adc_valid_i = 1'b0;
  logic [15:0] adc_data_i = 16'h8000;
  logic dsp_check_fail_i = 1'b0;
  logic [31:0] mem_word_i, avs_readdata_o, q, mword = 32'h0;
  logic mem_ack_i, avs_waitrequest_o, mem_rd_o, prog_mode_o, ecc_fault_o, ref_sel;
  logic [7:0] mem_addr_o, diag_flags_o;
  logic [1:0] out_state_o;
  logic [3:0] mlat = 4'h0;
  int miscompares = 0, checked = 0, i;
  logic signed [11:0] tv [7] = '{12'sd161, 12'sd160, -12'sd55, -12'sd56, 12'sd25, 12'sd25, 12'sd25};
  logic [2:0] fv [7] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h4, 3'h2, 3'h1};
  logic [7:0] ev [7] = '{8'h20, 8'h00, 8'h00, 8'h20, 8'h04, 8'h80, 8'h40};
  always #2.5 clk_i = ~clk_i;
  sfd_diag #(.UV_HOLD_TICKS(24'd5), .PO_DELAY_TICKS(24'd3)) dut (.clk_i, .sys_rst_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
    .avs_readdata_o, .avs_waitrequest_o, .low_supply_detector_i, .overvolt_upper_level_i,
    .overvolt_lower_level_i, .highvolt_level_i, .temp_c_i, .clamp_low_i, .clamp_high_i,
    .adc_overrange_i, .adc_slot_i, .adc_valid_i, .adc_data_i, .dsp_check_fail_i, .mem_addr_o,
    .mem_rd_o, .mem_word_i, .mem_ack_i, .adc_ref_sel_o(ref_sel), .out_state_o, .diag_flags_o,
    .prog_mode_o, .ecc_fault_o);
  sfd_mem_model u_mem (.clk_i, .rd_i(mem_rd_o), .word_i(mword), .lat_i(mlat),
    .ack_o(mem_ack_i), .word_o(mem_word_i));
  task automatic final_report();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_read_i <= !we;
    avs_write_i <= we;
    avs_address_i <= a;
    avs_writedata_i <= d;
    // sampled at the rising edge, before the design's own updates of that edge land
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 100);
    if (avs_waitrequest_o !== 1'b0) begin
      miscompares++;
      final_report();
    end
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  // one converter slot start (v low) or one conversion result (v high)
  task automatic adc_pulse(input logic v, input logic [15:0] d);
    @(posedge clk_i);
    adc_slot_i <= !v;
    adc_valid_i <= v;
    adc_data_i <= d;
    @(posedge clk_i);
    adc_slot_i <= 1'b0;
    adc_valid_i <= 1'b0;
  endtask
  // six cycles cover synchronisers plus register, then sample mid-cycle
  task automatic chko(input logic [1:0] s, input logic [7:0] f, input logic [1:0] pe);
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    chk({20'h0, prog_mode_o, ecc_fault_o, out_state_o, diag_flags_o}, {20'h0, pe, s, f});
    @(posedge clk_i);
  endtask
  function automatic logic [31:0] enc(input logic [25:0] d);
    int j, k;
    logic [31:0] w;
    w = 32'h0;
    k = 0;
    for (j = 1; j < 32; j++) if ((j & (j - 1)) != 0) w[j] = d[k++];
    for (j = 0; j < 5; j++) for (k = 3; k < 32; k++) if (k[j] && (k & (k - 1)) != 0) w[1 << j] ^= w[k];
    w[0] = ^w;
    return w;
  endfunction
  initial begin
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h0000715F);
    chko(2'h3, 8'h00, 2'h0);
    repeat (700) @(posedge clk_i);
    chko(2'h0, 8'h00, 2'h0);
    bus(1'b1, 4'h0, 32'hFF00715F);
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h0000715F);
    bus(1'b0, 4'h3, 32'h0);
    chk(q, 32'h0);
    low_supply_detector_i <= 1'b1;
    chko(2'h1, 8'h08, 2'h0);
    low_supply_detector_i <= 1'b0;
    chko(2'h1, 8'h08, 2'h0);
    repeat (1100) @(posedge clk_i);
    chko(2'h0, 8'h00, 2'h0);
    bus(1'b1, 4'h0, 32'h0000713F);
    low_supply_detector_i <= 1'b1;
    chko(2'h2, 8'h08, 2'h0);
    low_supply_detector_i <= 1'b0;
    chko(2'h0, 8'h00, 2'h0);
    bus(1'b1, 4'h0, 32'h0000715D);
    low_supply_detector_i <= 1'b1;
    chko(2'h0, 8'h00, 2'h0);
    low_supply_detector_i <= 1'b0;
    $display("test supply done");
    for (i = 0; i < 7; i++) begin
      temp_c_i <= tv[i];
      {dsp_check_fail_i, clamp_high_i, clamp_low_i} <= fv[i];
      chko({1'b0, |ev[i]}, ev[i], 2'h0);
    end
    {dsp_check_fail_i, clamp_high_i, clamp_low_i} <= 3'h0;
    bus(1'b1, 4'h0, 32'h000011DD);
    @(negedge clk_i);
    chk({31'h0, ref_sel}, 32'h0);
    adc_pulse(1'b0, 16'h6000);
    @(negedge clk_i);
    chk({31'h0, ref_sel}, 32'h1);
    adc_pulse(1'b1, 16'h6000);
    chko(2'h0, 8'h00, 2'h0);
    adc_pulse(1'b0, 16'h6000);
    adc_pulse(1'b1, 16'h6000);
    chko(2'h1, 8'h04, 2'h0);
    bus(1'b1, 4'h0, 32'h0000115D);
    chko(2'h0, 8'h00, 2'h0);
    adc_overrange_i <= 1'b1;
    chko(2'h1, 8'h80, 2'h0);
    adc_data_i <= 16'h8000;
    chko(2'h1, 8'h40, 2'h0);
    adc_overrange_i <= 1'b0;
    bus(1'b1, 4'h8, 32'h00000005);
    chk({24'h0, mem_addr_o}, 32'h00000005);
    mword <= enc(26'h2ABCDEF);
    bus(1'b0, 4'hC, 32'h0);
    chk(q, 32'h02ABCDEF);
    mword <= enc(26'h2ABCDEF) ^ 32'h00000080;
    mlat <= 4'h5;
    bus(1'b0, 4'hC, 32'h0);
    chk(q, 32'h12ABCDEF);
    chko(2'h0, 8'h00, 2'h0);
    $display("test detectors done");
    bus(1'b1, 4'h0, 32'h00C0715D);
    {overvolt_upper_level_i, overvolt_lower_level_i} <= 2'h3;
    chko(2'h1, 8'h10, 2'h0);
    overvolt_upper_level_i <= 1'b0;
    chko(2'h1, 8'h10, 2'h0);
    overvolt_lower_level_i <= 1'b0;
    chko(2'h0, 8'h00, 2'h0);
    highvolt_level_i <= 1'b1;
    chko(2'h2, 8'h00, 2'h0);
    highvolt_level_i <= 1'b0;
    chko(2'h0, 8'h00, 2'h0);
    bus(1'b1, 4'h0, 32'h0060715D);
    {overvolt_upper_level_i, overvolt_lower_level_i} <= 2'h3;
    chko(2'h2, 8'h00, 2'h2);
    mword <= enc(26'h2ABCDEF) ^ 32'h00000006;
    bus(1'b0, 4'hC, 32'h0);
    chk(q, 32'h22ABCDEF);
    chko(2'h2, 8'h01, 2'h3);
    bus(1'b0, 4'h4, 32'h0);
    chk(q, 32'h00001601);
    sys_rst_i <= 1'b1;
    {overvolt_upper_level_i, overvolt_lower_level_i} <= 2'h0;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    chko(2'h3, 8'h00, 2'h0);
    $display("test faults done");
    final_report();
  end
endmodule // tb_top
`default_nettype wire
